// File: core/swd_pkg.sv
// Purpose: Shared constants and types for the standby wake detect block
// Assumes: One 32-bit register word per offset, four inputs per config word
// Notes:   Each config byte lane is {zero, mode[2:0], edge[1:0], undefined, enable}
package swd_pkg;

  localparam int NUM_WAKE  = 8;
  localparam int LANES     = 4;
  localparam int LANE_W    = 8;
  localparam int ADDR_W    = 5;
  localparam int MODE_W    = 3;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CFG_LOW_OFFSET   = 5'h00;
  localparam logic [ADDR_W-1:0] CFG_HIGH_OFFSET  = 5'h04;
  localparam logic [ADDR_W-1:0] REQ_CLEAR_OFFSET = 5'h08;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET  = 5'h0c;

  // Field positions inside one byte lane
  localparam int ZERO_BIT  = 7;
  localparam int MODE_LSB  = 4;
  localparam int EDGE_LSB  = 2;
  localparam int UNDEF_BIT = 1;
  localparam int EN_BIT    = 0;

  // Detection mode codes
  localparam logic [2:0] MODE_LOW   = 3'h0;
  localparam logic [2:0] MODE_HIGH  = 3'h1;
  localparam logic [2:0] MODE_FALL  = 3'h2;
  localparam logic [2:0] MODE_RISE  = 3'h3;
  localparam logic [2:0] MODE_BOTH  = 3'h4;
  localparam logic [2:0] MODE_RESET = MODE_FALL;

  // Edge report codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [7:0] MASK_RESET = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [MODE_W-1:0] mode;
    logic              en;
  } swd_lane_cfg_t;

  localparam swd_lane_cfg_t LANE_CFG_RESET = '{mode: MODE_RESET, en: 1'b0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } swd_wr_t;

endpackage

// File: core/swd_wake_detect.sv
// Purpose: One wake input: synchroniser, level/edge detect, sticky request
// Assumes: Pin is asynchronous to clk
// Notes:   Illegal mode codes never raise a request
module swd_wake_detect (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   pin,
  input  swd_pkg::swd_lane_cfg_t      cfg,
  input  wire logic                   clr,
  output logic                        pending,
  output logic [1:0]                  edge_report
);
  import swd_pkg::*;

  logic       sync1_reg;
  logic       sync2_reg;
  logic       prev_reg;
  logic       pending_reg;
  logic [1:0] edge_reg;
  logic       rise;
  logic       fall;
  logic       hit;
  logic       set_edge;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;

  always_comb begin
    unique case (cfg.mode)
      MODE_LOW:  hit = ~sync2_reg;
      MODE_HIGH: hit = sync2_reg;
      MODE_FALL: hit = fall;
      MODE_RISE: hit = rise;
      MODE_BOTH: hit = rise | fall;
      default:   hit = 1'b0;
    endcase
  end

  // New request beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pending_reg <= 1'b0;
    end else begin
      pending_reg <= (cfg.en & hit) | (pending_reg & ~clr);
    end
  end

  assign set_edge = cfg.en & (cfg.mode == MODE_BOTH) & (rise | fall);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      edge_reg <= EDGE_NONE;
    end else if (set_edge) begin
      edge_reg <= (clr ? EDGE_NONE : edge_reg) | {fall, rise};
    end else if (clr) begin
      edge_reg <= EDGE_NONE;
    end
  end

  assign pending     = pending_reg;
  assign edge_report = edge_reg;

  property p_low_level_hit;
    @(posedge clk) disable iff (!nrst)
      cfg.en && cfg.mode == MODE_LOW && !sync2_reg |=> pending_reg;
  endproperty
  a_low_level_hit: assert property (p_low_level_hit)
    else $error("Enabled low level did not raise a request");

  property p_rise_report;
    @(posedge clk) disable iff (!nrst)
      cfg.en && cfg.mode == MODE_BOTH && rise && !clr |=> edge_reg[0] && pending_reg;
  endproperty
  a_rise_report: assert property (p_rise_report)
    else $error("Rising edge in both-edge mode not reported");

endmodule // swd_wake_detect

// File: core/swd_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the wake detect registers
// Assumes: One write and one read outstanding at most
// Notes:   Write lands one cycle after both AW and W are held
module swd_axil_slave (
  input  wire logic                        clk,
  input  wire logic                        nrst,
  input  wire logic [swd_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  output swd_pkg::swd_wr_t                 wr,
  output logic                             wr_valid,
  input  wire logic                        wr_hit,
  input  wire logic [31:0]                 rd_data,
  input  wire logic                        rd_hit
);
  import swd_pkg::*;

  logic                 aw_full_reg;
  logic                 w_full_reg;
  logic [ADDR_W-1:0]    aw_addr_reg;
  logic [31:0]          w_data_reg;
  logic [3:0]           w_strb_reg;
  logic                 bvalid_reg;
  logic [1:0]           bresp_reg;
  logic                 rvalid_reg;
  logic [1:0]           rresp_reg;
  logic [31:0]          rdata_reg;

  assign awready  = ~aw_full_reg;
  assign wready   = ~w_full_reg;
  assign wr_valid = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr       = '{addr: aw_addr_reg, data: w_data_reg, strb: w_strb_reg};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_valid) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign arready = ~rvalid_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end else if (arvalid && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg  <= rd_hit ? rd_data : '0;
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rresp  = rresp_reg;
  assign rdata  = rdata_reg;

endmodule // swd_axil_slave

// File: core/swd_top.sv
// Purpose: Standby wake detect configuration, status and request logic
// Assumes: CORE_CLK at 40 MHz, wake pins asynchronous, AXI4-Lite register access
// Notes:   Inputs 4..7 sit in the low config word, 8..11 in the high one
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.

// Summary of operation
// - Mode codes: 000 low, 001 high, 010 fall, 011 rise, 100 both edges.
// - Edge report reads 01 rising, 10 falling, 11 both, 00 nothing.
// - Edge report only records edges while the input's mode is both edges.
// - Clearing a pending request also zeroes that input's edge report.
// - Enable bit per input; zero blocks requests, one allows them.
// - Lane layout: mode in bits 6-4, edge in 3-2, enable bit 0.
// - Low config word holds inputs 4,5,6,7 in lanes 0 to 3.
// - High config word holds inputs 8,9,A,B in lanes 0 to 3.
// - Lane bit 7 reads zero; bit 1 is undefined, driven zero here.
module swd_top #(
  parameter int WAKE_COUNT = swd_pkg::NUM_WAKE
) (
  input  wire logic                        CORE_CLK,
  input  wire logic                        NRST,
  input  wire logic [swd_pkg::ADDR_W-1:0]  AWADDR,
  input  wire logic                        AWVALID,
  output logic                             AWREADY,
  input  wire logic [31:0]                 WDATA,
  input  wire logic [3:0]                  WSTRB,
  input  wire logic                        WVALID,
  output logic                             WREADY,
  output logic [1:0]                       BRESP,
  output logic                             BVALID,
  input  wire logic                        BREADY,
  input  wire logic [swd_pkg::ADDR_W-1:0]  ARADDR,
  input  wire logic                        ARVALID,
  output logic                             ARREADY,
  output logic [31:0]                      RDATA,
  output logic [1:0]                       RRESP,
  output logic                             RVALID,
  input  wire logic                        RREADY,
  input  wire logic [WAKE_COUNT-1:0]       EXTERNAL_WAKE_INPUT,
  output logic [WAKE_COUNT-1:0]            WAKE_REQ,
  output logic                             STANDBY_CLEAR,
  output logic                             IRQ
);
  import swd_pkg::*;

  // Layout is fixed at two words of four lanes
  if (WAKE_COUNT != 2 * LANES) begin : g_bad_count
    $error("WAKE_COUNT must equal two register words of lanes");
  end

  swd_lane_cfg_t          cfg_reg [WAKE_COUNT];
  logic [7:0]             mask_reg;
  logic [WAKE_COUNT-1:0]  pend_vec;
  logic [WAKE_COUNT-1:0]  clr_vec;
  logic [1:0]             edge_rpt [WAKE_COUNT];
  swd_wr_t                wr;
  logic                   wr_valid;
  logic                   wr_hit;
  logic [31:0]            rd_data;
  logic                   rd_hit;
  logic [ADDR_W-3:0]      wr_word;
  logic [ADDR_W-3:0]      rd_word;

  function automatic logic [ADDR_W-3:0] word_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  function automatic logic [LANE_W-1:0] pack_lane(input swd_lane_cfg_t c,
                                                  input logic [1:0]    e);
    logic [LANE_W-1:0] v;
    v                          = '0;
    v[MODE_LSB +: MODE_W]      = c.mode;
    v[EDGE_LSB +: 2]           = e;
    v[EN_BIT]                  = c.en;
    return v;
  endfunction

  swd_axil_slave u_bus (
    .clk      (CORE_CLK),
    .nrst     (NRST),
    .awaddr   (AWADDR),
    .awvalid  (AWVALID),
    .awready  (AWREADY),
    .wdata    (WDATA),
    .wstrb    (WSTRB),
    .wvalid   (WVALID),
    .wready   (WREADY),
    .bresp    (BRESP),
    .bvalid   (BVALID),
    .bready   (BREADY),
    .arvalid  (ARVALID),
    .arready  (ARREADY),
    .rdata    (RDATA),
    .rresp    (RRESP),
    .rvalid   (RVALID),
    .rready   (RREADY),
    .wr       (wr),
    .wr_valid (wr_valid),
    .wr_hit   (wr_hit),
    .rd_data  (rd_data),
    .rd_hit   (rd_hit)
  );

  assign wr_word = word_of(wr.addr);
  assign rd_word = word_of(ARADDR);
  assign wr_hit  = (wr_word == word_of(CFG_LOW_OFFSET))   ||
                   (wr_word == word_of(CFG_HIGH_OFFSET))  ||
                   (wr_word == word_of(REQ_CLEAR_OFFSET)) ||
                   (wr_word == word_of(IRQ_MASK_OFFSET));

  // Config writes, byte lane by byte lane
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      for (int i = 0; i < WAKE_COUNT; i++) begin
        cfg_reg[i] <= LANE_CFG_RESET;
      end
    end else if (wr_valid) begin
      for (int j = 0; j < LANES; j++) begin
        if (wr.strb[j] && wr_word == word_of(CFG_LOW_OFFSET)) begin
          cfg_reg[j].mode <= wr.data[j*LANE_W+MODE_LSB +: MODE_W];
          cfg_reg[j].en   <= wr.data[j*LANE_W+EN_BIT];
        end
        if (wr.strb[j] && wr_word == word_of(CFG_HIGH_OFFSET)) begin
          cfg_reg[j+LANES].mode <= wr.data[j*LANE_W+MODE_LSB +: MODE_W];
          cfg_reg[j+LANES].en   <= wr.data[j*LANE_W+EN_BIT];
        end
      end
    end
  end

  // Mask only gates the interrupt, never the wake request itself
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      mask_reg <= MASK_RESET;
    end else if (wr_valid && wr.strb[0] && wr_word == word_of(IRQ_MASK_OFFSET)) begin
      mask_reg <= wr.data[7:0];
    end
  end

  // Write one to clear a pending request
  always_comb begin
    clr_vec = '0;
    if (wr_valid && wr.strb[0] && wr_word == word_of(REQ_CLEAR_OFFSET)) begin
      clr_vec = wr.data[WAKE_COUNT-1:0];
    end
  end

  for (genvar g = 0; g < WAKE_COUNT; g++) begin : g_wake
    swd_wake_detect u_det (
      .clk         (CORE_CLK),
      .nrst        (NRST),
      .pin         (EXTERNAL_WAKE_INPUT[g]),
      .cfg         (cfg_reg[g]),
      .clr         (clr_vec[g]),
      .pending     (pend_vec[g]),
      .edge_report (edge_rpt[g])
    );
  end

  // Read decode; undefined bit 1 is driven zero for determinism
  always_comb begin
    rd_data = '0;
    rd_hit  = 1'b1;
    if (rd_word == word_of(CFG_LOW_OFFSET)) begin
      for (int j = 0; j < LANES; j++) begin
        rd_data[j*LANE_W +: LANE_W] = pack_lane(cfg_reg[j], edge_rpt[j]);
      end
    end else if (rd_word == word_of(CFG_HIGH_OFFSET)) begin
      for (int j = 0; j < LANES; j++) begin
        rd_data[j*LANE_W +: LANE_W] = pack_lane(cfg_reg[j+LANES], edge_rpt[j+LANES]);
      end
    end else if (rd_word == word_of(REQ_CLEAR_OFFSET)) begin
      rd_data[WAKE_COUNT-1:0] = pend_vec;
    end else if (rd_word == word_of(IRQ_MASK_OFFSET)) begin
      rd_data[7:0] = mask_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign WAKE_REQ      = pend_vec;
  assign STANDBY_CLEAR = |pend_vec;
  assign IRQ           = |(pend_vec & mask_reg[WAKE_COUNT-1:0]);

  // Checks
  logic [WAKE_COUNT-1:0] en_vec;
  logic [WAKE_COUNT-1:0] bad_mode_vec;
  always_comb begin
    for (int i = 0; i < WAKE_COUNT; i++) begin
      en_vec[i]       = cfg_reg[i].en;
      bad_mode_vec[i] = cfg_reg[i].mode > MODE_BOTH;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_reset_defaults;
    $rose(NRST) |-> cfg_reg[0].mode == MODE_RESET && !cfg_reg[WAKE_COUNT-1].en
                    && edge_rpt[0] == EDGE_NONE && !IRQ && mask_reg == MASK_RESET;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Reset values not in place after reset release");

  property p_disabled_silent;
    ((pend_vec & ~$past(pend_vec) & ~$past(en_vec)) == '0);
  endproperty
  a_disabled_silent: assert property (p_disabled_silent)
    else $error("Disabled input raised a request");

  property p_pending_sticky;
    pend_vec[0] && !clr_vec[0] ##1 !clr_vec[0] |=> pend_vec[0];
  endproperty
  a_pending_sticky: assert property (p_pending_sticky)
    else $error("Pending request dropped without a clear");

  // A new edge in the clear cycle wins and also sets the request
  property p_clear_edge;
    clr_vec[4] |=> edge_rpt[4] == EDGE_NONE || pend_vec[4];
  endproperty
  a_clear_edge: assert property (p_clear_edge)
    else $error("Edge report not zeroed by request clear");

  property p_edge_only_both;
    cfg_reg[2].mode != MODE_BOTH && edge_rpt[2] == EDGE_NONE |=> edge_rpt[2] == EDGE_NONE;
  endproperty
  a_edge_only_both: assert property (p_edge_only_both)
    else $error("Edge report changed outside both-edge mode");

  property p_read_low_layout;
    ARVALID && ARREADY && word_of(ARADDR) == word_of(CFG_LOW_OFFSET)
      |=> RVALID && RDATA[6:4] == $past(cfg_reg[0].mode) && RDATA[0] == $past(cfg_reg[0].en)
          && RDATA[31:29] == {1'b0, $past(cfg_reg[3].mode[2:1])} && RDATA[1] == 1'b0;
  endproperty
  a_read_low_layout: assert property (p_read_low_layout)
    else $error("Low config word read does not match lane layout");

  property p_read_high_layout;
    ARVALID && ARREADY && word_of(ARADDR) == word_of(CFG_HIGH_OFFSET)
      |=> RVALID && RDATA[14:12] == $past(cfg_reg[5].mode) && RDATA[23] == 1'b0
          && RDATA[11:10] == $past(edge_rpt[5]) && RDATA[24] == $past(cfg_reg[7].en);
  endproperty
  a_read_high_layout: assert property (p_read_high_layout)
    else $error("High config word read does not match lane layout");

  property p_write_lands;
    wr_valid && wr.strb[0] && word_of(wr.addr) == word_of(CFG_LOW_OFFSET)
      |=> cfg_reg[0].mode == $past(wr.data[6:4]) && cfg_reg[0].en == $past(wr.data[0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("Lane 0 write did not land in mode and enable");

  // Request invariants over every input, prohibited mode codes included; then single word and lane read/write checks
  property p_bad_mode_silent;
    ((pend_vec & ~$past(pend_vec) & $past(bad_mode_vec)) == '0);
  endproperty
  a_bad_mode_silent: assert property (p_bad_mode_silent)
    else $error("Prohibited mode code raised a request");

  property p_pending_only_clear;
    ((~pend_vec & $past(pend_vec) & ~$past(clr_vec)) == '0);
  endproperty
  a_pending_only_clear: assert property (p_pending_only_clear)
    else $error("Pending request fell without a clear");

  property p_read_zero_bits;
    ARVALID && ARREADY && word_of(ARADDR) == word_of(CFG_HIGH_OFFSET)
      |=> (RDATA & 32'h82828282) == 32'h0;
  endproperty
  a_read_zero_bits: assert property (p_read_zero_bits)
    else $error("Reserved config bits did not read zero");

  property p_read_pending;
    ARVALID && ARREADY && word_of(ARADDR) == word_of(REQ_CLEAR_OFFSET)
      |=> RVALID && RDATA == 32'($past(pend_vec));
  endproperty
  a_read_pending: assert property (p_read_pending)
    else $error("Pending read does not match requests");

  property p_write_high_lands;
    wr_valid && wr.strb[3] && wr_word == word_of(CFG_HIGH_OFFSET)
      |=> cfg_reg[7].mode == $past(wr.data[30:28]) && cfg_reg[7].en == $past(wr.data[24]);
  endproperty
  a_write_high_lands: assert property (p_write_high_lands)
    else $error("Lane 3 write did not land in the high word");

  property p_enable_write;
    wr_valid && wr.strb[1] && wr_word == word_of(CFG_LOW_OFFSET)
      |=> en_vec[1] == $past(wr.data[8]);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("Lane 1 enable write did not land");

  // Mask is software state only; a lost write would hide interrupts
  property p_mask_write;
    wr_valid && wr.strb[0] && wr_word == word_of(IRQ_MASK_OFFSET)
      |=> mask_reg == $past(wr.data[7:0]);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("Mask write did not land");

  c_both_edge_wake: cover property (cfg_reg[0].mode == MODE_BOTH && $rose(pend_vec[0]));
  c_clear_pending: cover property (pend_vec[3] && clr_vec[3] ##1 !pend_vec[3]);
  c_irq_raised: cover property ($rose(IRQ));
  c_level_wake: cover property (cfg_reg[0].mode == MODE_LOW && $rose(pend_vec[0]));
  c_fall_report: cover property (edge_rpt[4] == EDGE_FALL);

endmodule // swd_top

// File: bench/swd_pin_src.sv
// Purpose: Behavioural sources for the eight external wake pins
// Assumes: Pins change just after a rising clock edge
// Notes:   Caller keeps every level at least 2 cycles so it is seen
module swd_pin_src (
  input  wire logic       clk,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;

  initial pins = 8'h00;

  // Push-pull sources, so the pin always shows a real level
  task automatic drive(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
  endtask

endmodule // swd_pin_src

// File: bench/tb.sv
// Purpose: Register and wake request checks for the wake detect block
// Assumes: Bus tasks are entered just after a rising edge
// Notes:   Slot i of the pin bus is input 4+i
module tb import swd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic              clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, standby_clear, irq;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [7:0]        wake_pin, wake_req;
  int                err_count, checks_done;

  swd_pin_src src_u (.clk(clk), .pins(wake_pin));

  swd_top dut_u (
    .CORE_CLK(clk), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EXTERNAL_WAKE_INPUT(wake_pin), .WAKE_REQ(wake_req), .STANDBY_CLEAR(standby_clear),
    .IRQ(irq)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hold each channel until its own ready; extra edge avoids a double drive
  task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] resp);
    bit aw_on, w_on;
    aw_on = 1;
    w_on = 1;
    resp = 2'h3;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (aw_on && awready) begin aw_on = 0; awvalid <= 1'b0; end
      if (w_on && wready) begin w_on = 0; wvalid <= 1'b0; end
      if (bvalid && !aw_on && !w_on) begin resp = bresp; break; end
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic bus_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
    bit ar_on;
    ar_on = 1;
    resp = 2'h3;
    d = 32'h0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar_on && arready) begin ar_on = 0; arvalid <= 1'b0; end
      else if (!ar_on && rvalid) begin d = rdata; resp = rresp; break; end
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr_ok(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    bus_wr(a, d, s, r);
    check("write response", 32'(r), 32'(RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd(a, d, r);
    check("read response", 32'(r), 32'(RESP_OKAY));
    check(what, d, exp);
  endtask

  task automatic cfg_lane(input int idx, input logic [7:0] lane);
    wr_ok((idx < 4) ? CFG_LOW_OFFSET : CFG_HIGH_OFFSET, {4{lane}}, 4'(1 << (idx % 4)));
  endtask

  task automatic edge_chk(input int idx, input logic [1:0] exp, input string what);
    logic [31:0] d;
    logic [1:0]  r;
    bus_rd((idx < 4) ? CFG_LOW_OFFSET : CFG_HIGH_OFFSET, d, r);
    check(what, 32'(d[(idx % 4) * 8 + EDGE_LSB +: 2]), 32'(exp));
  endtask

  // Clear while the pin is active tells level modes from edge modes
  task automatic mode_case(input int idx, input logic [2:0] mode);
    logic       idle, lvl, both;
    logic [7:0] bit_i;
    idle = (mode == MODE_LOW) || (mode == MODE_FALL);
    lvl = (mode == MODE_LOW) || (mode == MODE_HIGH);
    both = (mode == MODE_BOTH);
    bit_i = 8'h01 << idx;
    src_u.drive(idx, idle);
    cyc(4);
    cfg_lane(idx, {1'b0, mode, 4'h0});
    src_u.drive(idx, !idle);
    cyc(3);
    src_u.drive(idx, idle);
    cyc(4);
    check("request while disabled", 32'(wake_req), 32'h0);
    cfg_lane(idx, {1'b0, mode, 4'h1});
    cyc(4);
    check("request at idle level", 32'(wake_req), 32'h0);
    src_u.drive(idx, !idle);
    cyc(4);
    check("request on active", 32'(wake_req), 32'(bit_i));
    check("standby clear out", 32'(standby_clear), 32'h1);
    edge_chk(idx, both ? EDGE_RISE : EDGE_NONE, "edge after rise");
    wr_ok(REQ_CLEAR_OFFSET, 32'(bit_i), 4'h1);
    cyc(2);
    check("request after clear", 32'(wake_req), lvl ? 32'(bit_i) : 32'h0);
    edge_chk(idx, EDGE_NONE, "edge after clear");
    src_u.drive(idx, idle);
    cyc(4);
    check("request on release", 32'(wake_req), (lvl || both) ? 32'(bit_i) : 32'h0);
    edge_chk(idx, both ? EDGE_FALL : EDGE_NONE, "edge after fall");
    wr_ok(REQ_CLEAR_OFFSET, 32'(bit_i), 4'h1);
    cyc(2);
    check("request after final clear", 32'(wake_req), 32'h0);
    cfg_lane(idx, {1'b0, mode, 4'h0});
    $display("test mode %0d on slot %0d done", mode, idx);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    stop_test();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    err_count = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd_chk(CFG_LOW_OFFSET, 32'h20202020, "low config reset");
    rd_chk(CFG_HIGH_OFFSET, 32'h20202020, "high config reset");
    rd_chk(REQ_CLEAR_OFFSET, 32'h0, "pending reset");
    rd_chk(IRQ_MASK_OFFSET, 32'h0, "mask reset");
    check("irq after reset", 32'({irq, wake_req}), 32'h0);
    $display("test reset values done");
    // Legal modes only, enables clear; top, edge and spare bits written as ones
    wr_ok(CFG_LOW_OFFSET, 32'hce8e9ebe, 4'hf);
    rd_chk(CFG_LOW_OFFSET, 32'h40001030, "low config layout");
    wr_ok(CFG_HIGH_OFFSET, 32'h8e9ebece, 4'hf);
    rd_chk(CFG_HIGH_OFFSET, 32'h00103040, "high config layout");
    bus_wr(5'h10, 32'hffffffff, 4'hf, r);
    check("unmapped write response", 32'(r), 32'(RESP_SLVERR));
    bus_rd(5'h14, d, r);
    check("unmapped read response", 32'(r), 32'(RESP_SLVERR));
    rd_chk(CFG_LOW_OFFSET, 32'h40001030, "low config kept");
    $display("test layout done");
    for (int m = 0; m <= 4; m++) mode_case(m, 3'(m));
    // Input B: rise mode, mask gates the interrupt only
    cfg_lane(7, {1'b0, MODE_RISE, 4'h0});
    cfg_lane(7, {1'b0, MODE_RISE, 4'h1});
    src_u.drive(7, 1'b1);
    cyc(4);
    check("masked irq", 32'({irq, standby_clear, wake_req}), 32'h180);
    wr_ok(IRQ_MASK_OFFSET, 32'h80, 4'h1);
    check("unmasked irq", 32'(irq), 32'h1);
    rd_chk(REQ_CLEAR_OFFSET, 32'h80, "pending read");
    wr_ok(REQ_CLEAR_OFFSET, 32'h80, 4'h1);
    check("irq after clear", 32'({irq, wake_req}), 32'h0);
    $display("test interrupt done");
    stop_test();
  end

endmodule // tb
